// ### rtl/mcs_pkg.sv
`include "mcs_regs.svh"

package mcs_pkg;

    typedef enum logic [2:0] {
        MCS_IDLE, MCS_T1, MCS_T2, MCS_T3, MCS_T4, MCS_T5, MCS_T6, MCS_PAD
    } mcs_state_t;

    typedef struct packed {
        logic [`MCS_UCNT_W-1:0] cnt;
        logic pclk;
    } mcs_ugen_t;

    typedef struct packed {
        logic [`MCS_SY_W-1:0] meta;
        logic [`MCS_SY_W-1:0] sync;
        mcs_state_t st;
        logic [`MCS_TLEN_W-1:0] cnt;
        logic [`MCS_EL_W-1:0] el;
        logic par;
        logic pend;
        logic wr;
        logic [`MCS_DW-1:0] addr;
        logic [`MCS_DW-1:0] wdata;
        logic [`MCS_LANES-1:0] be;
        logic lock;
        logic late;
        logic [`MCS_TLEN_BITS-1:0] tlen;
        logic [`MCS_SOFF_BITS-1:0] soff;
        logic grant;
        logic rsp_v;
        logic [`MCS_DW-1:0] rsp_data;
        logic [`MCS_DW-1:0] rd_data;
        logic [`MCS_DW-1:0] bus_o;
        logic [`MCS_LANES-1:0] bus_oe_n;
        logic [4:0] s_n;
        logic [`MCS_LANES-1:0] wr_n;
        logic rd_n;
        logic [`MCS_MEM_WORDS-1:0][`MCS_DW-1:0] mem;
    } mcs_seq_t;

endpackage : mcs_pkg

// ### rtl/mcs_regs.svh
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

`define MCS_RA_W 8
`define MCS_OFF_CTRL 8'h00
`define MCS_OFF_TLEN 8'h04
`define MCS_OFF_SOFF 8'h08
`define MCS_OFF_STAT 8'h0C

`define MCS_CTRL_LOCK 0
`define MCS_CTRL_LATE 1

`define MCS_TLEN_W 2
`define MCS_TLEN_BITS 12
`define MCS_TLEN_RST 12'h000

`define MCS_SOFF_W 5
`define MCS_SOFF_BITS 20
`define MCS_SOFF_RST 20'h08421
`define MCS_SOFF_MIN 5'h01

`define MCS_EL_W 6
`define MCS_EL_MAX 6'h3F

`define MCS_INT_TAG 20'h80000
`define MCS_INT_HI 31
`define MCS_INT_LO 12
`define MCS_IDX_HI 11
`define MCS_IDX_LO 2
`define MCS_MEM_WORDS 1024
`define MCS_FIRST_USER 32'h80000070

`define MCS_BYTE_W 8
`define MCS_LANES 4
`define MCS_DW 32

`define MCS_SY_W 35
`define MCS_SY_WAIT 32
`define MCS_SY_REQ 33
`define MCS_SY_SETUP 34

`define MCS_UNIT_NS 20
`define MCS_CLK_NS 10
`define MCS_UNIT_CYC (`MCS_UNIT_NS / `MCS_CLK_NS)
`define MCS_UCNT_W 4

`endif

// ### rtl/mcs_sequencer.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "mcs_regs.svh"

// What this block does
// - every external access steps through six timing states in order
// - each state lasts one to four units, set separately per state
// - one unit is half a processor clock period
// - only the fourth state grows, two units (one processor clock) per wait step
// - an odd unit total gets one padding unit after the sixth state
// - four strobe edges are programmable 1 to 31 units after second state
// - strobe a starts at second state, ends at its count or sixth end
// - address strobe second to fifth state; strobes b-d start late, end at sixth
// - strobe a's end ignores wait states
// - 32-bit multiplexed bus over a 4 Gbyte signed byte space
// - byte writes, read, five strobes, wait, setup, request and grant; refresh strobe held inactive
// - first 4 Kbytes are on-chip single-cycle memory, user space from 80000070
// - addresses from 80001000 upward run as external cycles
// - bus drives address through second state, then floats or drives write lanes
// - wait input high holds the fourth state; fifth starts on a rising clock
// - byte write strobes fall at third or fourth state, rise at sixth

module mcs_sequencer (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [`MCS_RA_W-1:0] reg_addr,
    input wire logic [`MCS_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`MCS_DW-1:0] reg_rdata,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [`MCS_DW-1:0] req_addr,
    input wire logic req_write,
    input wire logic [`MCS_DW-1:0] req_wdata,
    input wire logic [`MCS_LANES-1:0] req_be,
    output logic rsp_valid,
    output logic [`MCS_DW-1:0] rsp_rdata,
    input wire logic [`MCS_DW-1:0] muxed_addr_data_bus_i,
    output logic [`MCS_DW-1:0] muxed_addr_data_bus_o,
    output logic [`MCS_LANES-1:0] muxed_addr_data_bus_oe_n,
    output logic address_valid_strobe_n,
    output logic config_strobe_a_n,
    output logic config_strobe_b_n,
    output logic config_strobe_c_n,
    output logic config_strobe_d_n,
    output logic [`MCS_LANES-1:0] byte_write_strobes_n,
    output logic read_strobe_n,
    output logic refresh_strobe_n,
    input wire logic wait_request_input,
    input wire logic interface_setup_input,
    input wire logic bus_request_input,
    output logic bus_grant_output,
    output logic processor_clock_output
);

    ////////////////////////////////////////////////////////////////////////////
    // unit timing

    logic tick;
    logic rise;

    mcs_unit_gen u_unit (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .rise(rise),
        .proc_clk(processor_clock_output)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [`MCS_TLEN_W-1:0] tlen_f(input logic [`MCS_TLEN_BITS-1:0] t, input mcs_pkg::mcs_state_t s);
        logic [`MCS_TLEN_W-1:0] r;
        r = '0;
        unique case (s)
            mcs_pkg::MCS_T1: r = t[0*`MCS_TLEN_W +: `MCS_TLEN_W];
            mcs_pkg::MCS_T2: r = t[1*`MCS_TLEN_W +: `MCS_TLEN_W];
            mcs_pkg::MCS_T3: r = t[2*`MCS_TLEN_W +: `MCS_TLEN_W];
            mcs_pkg::MCS_T4: r = t[3*`MCS_TLEN_W +: `MCS_TLEN_W];
            mcs_pkg::MCS_T5: r = t[4*`MCS_TLEN_W +: `MCS_TLEN_W];
            mcs_pkg::MCS_T6: r = t[5*`MCS_TLEN_W +: `MCS_TLEN_W];
            mcs_pkg::MCS_IDLE, mcs_pkg::MCS_PAD: r = '0;
        endcase
        return r;
    endfunction : tlen_f

    function automatic logic [`MCS_SOFF_W-1:0] soff_f(input logic [`MCS_SOFF_BITS-1:0] o, input int k);
        return o[k*`MCS_SOFF_W +: `MCS_SOFF_W];
    endfunction : soff_f

    // signed space: only the 4 Kbyte window at the most negative address is on-chip
    function automatic logic internal_f(input logic [`MCS_DW-1:0] a);
        return a[`MCS_INT_HI:`MCS_INT_LO] == `MCS_INT_TAG;
    endfunction : internal_f

    function automatic logic in_range_f(input mcs_pkg::mcs_state_t s, input mcs_pkg::mcs_state_t lo,
                                        input mcs_pkg::mcs_state_t hi);
        return (s >= lo) && (s <= hi);
    endfunction : in_range_f

    ////////////////////////////////////////////////////////////////////////////
    // state

    mcs_pkg::mcs_seq_t q;
    mcs_pkg::mcs_seq_t d;
    logic take;
    logic last;
    logic wait_s;
    logic [`MCS_IDX_HI-`MCS_IDX_LO:0] idx;
    logic [`MCS_SOFF_BITS-1:0] soff_w;
    logic wr_win;

    assign wait_s = q.sync[`MCS_SY_WAIT];
    assign idx = req_addr[`MCS_IDX_HI:`MCS_IDX_LO];
    // refused while busy, granted away or unlocked
    assign req_ready = (q.st == mcs_pkg::MCS_IDLE) && !q.pend && q.lock && !q.grant;
    assign take = req_valid && req_ready;
    assign last = (q.cnt == tlen_f(q.tlen, q.st));

    always_comb begin
        d = q;
        soff_w = reg_wdata[`MCS_SOFF_BITS-1:0];
        wr_win = 1'b0;
        d.rsp_v = 1'b0;
        // pins pass two flops; only the second stage is ever read
        d.meta = {interface_setup_input, bus_request_input, wait_request_input, muxed_addr_data_bus_i};
        d.sync = q.meta;

        // register read data stand in the following cycle only
        d.rd_data = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                `MCS_OFF_CTRL: d.rd_data = {30'h00000000, q.late, q.lock};
                `MCS_OFF_TLEN: d.rd_data = {20'h00000, q.tlen};
                `MCS_OFF_SOFF: d.rd_data = {12'h000, q.soff};
                `MCS_OFF_STAT: d.rd_data = {25'h0000000, q.grant, q.sync[`MCS_SY_SETUP], wait_s, q.st, q.lock};
                default: d.rd_data = '0;
            endcase
        end

        // configuration is writable only before lock; lock clears only by reset
        if (reg_wr && !q.lock) begin
            unique case (reg_addr)
                `MCS_OFF_CTRL: begin
                    d.lock = reg_wdata[`MCS_CTRL_LOCK];
                    d.late = reg_wdata[`MCS_CTRL_LATE];
                end
                `MCS_OFF_TLEN: d.tlen = reg_wdata[`MCS_TLEN_BITS-1:0];
                `MCS_OFF_SOFF: begin
                    // a zero offset would mean no edge at all, so it reads as one unit
                    for (int k = 0; k < 4; k++) begin
                        if (soff_f(soff_w, k) == '0) begin
                            soff_w[k*`MCS_SOFF_W +: `MCS_SOFF_W] = `MCS_SOFF_MIN;
                        end
                    end
                    d.soff = soff_w;
                end
                default: ;
            endcase
        end

        // grant changes only between cycles, never while a cycle is pending
        if (q.st == mcs_pkg::MCS_IDLE && !q.pend && !take) begin
            d.grant = q.sync[`MCS_SY_REQ];
        end

        // processor requests: on-chip words answer next cycle, others start a cycle
        if (take) begin
            if (internal_f(req_addr)) begin
                d.rsp_v = 1'b1;
                d.rsp_data = q.mem[idx];
                if (req_write) begin
                    for (int i = 0; i < `MCS_LANES; i++) begin
                        if (req_be[i]) begin
                            d.mem[idx][i*`MCS_BYTE_W +: `MCS_BYTE_W] = req_wdata[i*`MCS_BYTE_W +: `MCS_BYTE_W];
                        end
                    end
                end
            end else begin
                d.pend = 1'b1;
                d.wr = req_write;
                d.addr = req_addr;
                d.wdata = req_wdata;
                d.be = req_write ? req_be : {`MCS_LANES{1'b1}};
            end
        end

        // timing state machine, advanced once per unit
        if (tick) begin
            if (q.st != mcs_pkg::MCS_IDLE) begin
                d.par = !q.par;
            end
            if (in_range_f(q.st, mcs_pkg::MCS_T2, mcs_pkg::MCS_T6) && q.el != `MCS_EL_MAX) begin
                d.el = q.el + `MCS_EL_W'(1);
            end
            if (in_range_f(q.st, mcs_pkg::MCS_T1, mcs_pkg::MCS_T6) && !last) begin
                d.cnt = q.cnt + `MCS_TLEN_W'(1);
            end
            unique case (q.st)
                mcs_pkg::MCS_IDLE: begin
                    // cycles start on a rising processor clock edge
                    if (q.pend && rise) begin
                        d.st = mcs_pkg::MCS_T1;
                        d.cnt = '0;
                        d.par = 1'b0;
                    end
                end
                mcs_pkg::MCS_T1: begin
                    if (last) begin
                        d.st = mcs_pkg::MCS_T2;
                        d.cnt = '0;
                        d.el = '0;
                    end
                end
                mcs_pkg::MCS_T2, mcs_pkg::MCS_T3: begin
                    if (last) begin
                        d.st = (q.st == mcs_pkg::MCS_T2) ? mcs_pkg::MCS_T3 : mcs_pkg::MCS_T4;
                        d.cnt = '0;
                    end
                end
                mcs_pkg::MCS_T4: begin
                    // extra units while wait is high, and until the next unit starts on a rising edge
                    if (last && !wait_s && rise) begin
                        d.st = mcs_pkg::MCS_T5;
                        d.cnt = '0;
                    end
                end
                mcs_pkg::MCS_T5: begin
                    if (last) begin
                        d.st = mcs_pkg::MCS_T6;
                        d.cnt = '0;
                        d.rsp_data = q.sync[`MCS_DW-1:0];
                    end
                end
                mcs_pkg::MCS_T6: begin
                    if (last) begin
                        d.cnt = '0;
                        if (d.par) begin
                            d.st = mcs_pkg::MCS_PAD;
                        end else begin
                            d.st = mcs_pkg::MCS_IDLE;
                            d.pend = 1'b0;
                            d.rsp_v = 1'b1;
                        end
                    end
                end
                mcs_pkg::MCS_PAD: begin
                    d.st = mcs_pkg::MCS_IDLE;
                    d.pend = 1'b0;
                    d.rsp_v = 1'b1;
                end
            endcase
        end

        // pin levels follow the next state so every pin leaves a flop
        d.s_n[0] = !in_range_f(d.st, mcs_pkg::MCS_T2, mcs_pkg::MCS_T5);
        d.s_n[1] = !(in_range_f(d.st, mcs_pkg::MCS_T2, mcs_pkg::MCS_T6) &&
                     d.el < `MCS_EL_W'(soff_f(d.soff, 0)));
        for (int k = 1; k < 4; k++) begin
            d.s_n[k+1] = !(in_range_f(d.st, mcs_pkg::MCS_T2, mcs_pkg::MCS_T5) &&
                           d.el >= `MCS_EL_W'(soff_f(d.soff, k)));
        end
        wr_win = d.late ? in_range_f(d.st, mcs_pkg::MCS_T4, mcs_pkg::MCS_T5)
                        : in_range_f(d.st, mcs_pkg::MCS_T3, mcs_pkg::MCS_T5);
        d.wr_n = ~({`MCS_LANES{d.wr && wr_win}} & d.be);
        d.rd_n = !(!d.wr && in_range_f(d.st, mcs_pkg::MCS_T4, mcs_pkg::MCS_T5));
        // address with cycle type in the two low bits, then write lanes or float
        if (in_range_f(d.st, mcs_pkg::MCS_T1, mcs_pkg::MCS_T2)) begin
            d.bus_o = {d.addr[`MCS_DW-1:`MCS_IDX_LO], 1'b1, !d.wr};
            d.bus_oe_n = '0;
        end else if (d.wr && in_range_f(d.st, mcs_pkg::MCS_T3, mcs_pkg::MCS_T6)) begin
            d.bus_o = d.wdata;
            d.bus_oe_n = ~d.be;
        end else begin
            d.bus_o = '0;
            d.bus_oe_n = {`MCS_LANES{1'b1}};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
            q.st <= mcs_pkg::MCS_IDLE;
            q.tlen <= `MCS_TLEN_RST;
            q.soff <= `MCS_SOFF_RST;
            q.s_n <= '1;
            q.wr_n <= '1;
            q.rd_n <= 1'b1;
            q.bus_oe_n <= '1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata = q.rd_data;
    assign rsp_valid = q.rsp_v;
    assign rsp_rdata = q.rsp_data;
    assign muxed_addr_data_bus_o = q.bus_o;
    assign muxed_addr_data_bus_oe_n = q.bus_oe_n;
    assign address_valid_strobe_n = q.s_n[0];
    assign config_strobe_a_n = q.s_n[1];
    assign config_strobe_b_n = q.s_n[2];
    assign config_strobe_c_n = q.s_n[3];
    assign config_strobe_d_n = q.s_n[4];
    assign byte_write_strobes_n = q.wr_n;
    assign read_strobe_n = q.rd_n;
    // no refresh controller here, so the refresh strobe stays inactive
    assign refresh_strobe_n = 1'b1;
    assign bus_grant_output = q.grant;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence t4_leave_s;
        q.st == mcs_pkg::MCS_T4 ##1 q.st == mcs_pkg::MCS_T5;
    endsequence

    sequence t1_leave_s;
        q.st == mcs_pkg::MCS_T1 ##1 q.st == mcs_pkg::MCS_T2;
    endsequence

    sequence cycle_end_s;
        q.st != mcs_pkg::MCS_IDLE ##1 q.st == mcs_pkg::MCS_IDLE;
    endsequence

    t5_rise_a: assert property (t4_leave_s |-> processor_clock_output && !$past(wait_s))
        else $error("fifth state began off a rising edge or under wait");
    strobe_start_a: assert property (t1_leave_s |-> !address_valid_strobe_n && !config_strobe_a_n)
        else $error("strobes not active at second state start");
    even_units_a: assert property (cycle_end_s |-> !q.par && rsp_valid)
        else $error("access ended after an odd unit count");
    t6_release_a: assert property (q.st == mcs_pkg::MCS_T6 |-> address_valid_strobe_n && config_strobe_b_n
                                   && config_strobe_c_n && config_strobe_d_n && (&byte_write_strobes_n))
        else $error("strobe still active in sixth state");
    strobe_a_end_a: assert property (in_range_f(q.st, mcs_pkg::MCS_T2, mcs_pkg::MCS_T6)
                                     && q.el >= `MCS_EL_W'(soff_f(q.soff, 0)) |-> config_strobe_a_n)
        else $error("strobe a active past its count");
    addr_phase_a: assert property (q.st == mcs_pkg::MCS_T2 |-> muxed_addr_data_bus_oe_n == '0
                                   && muxed_addr_data_bus_o[`MCS_DW-1:`MCS_IDX_LO] == q.addr[`MCS_DW-1:`MCS_IDX_LO])
        else $error("address not driven in second state");
    write_window_a: assert property (!(&byte_write_strobes_n) |-> q.wr && in_range_f(q.st,
                                     q.late ? mcs_pkg::MCS_T4 : mcs_pkg::MCS_T3, mcs_pkg::MCS_T5))
        else $error("write strobe outside its window");
    state_len_a: assert property (tick && q.st == mcs_pkg::MCS_T1 && q.cnt == tlen_f(q.tlen, q.st)
                                  |=> q.st == mcs_pkg::MCS_T2 && q.cnt == '0)
        else $error("first state length wrong");
    cfg_fixed_a: assert property ($past(q.lock) |-> q.lock && $stable(q.tlen) && $stable(q.soff))
        else $error("configuration changed after lock");
    internal_a: assert property (take && internal_f(req_addr) |=> rsp_valid && q.st == mcs_pkg::MCS_IDLE)
        else $error("on-chip access not single cycle");

endmodule : mcs_sequencer

// ### rtl/mcs_unit_gen.sv
`timescale 1ns/1ps
`include "mcs_regs.svh"

module mcs_unit_gen (
    input wire logic clk_sys,
    input wire logic rst,
    output logic tick,
    output logic rise,
    output logic proc_clk
);

    mcs_pkg::mcs_ugen_t q;
    mcs_pkg::mcs_ugen_t d;

    // one tick per half-clock unit
    always_comb begin
        d = q;
        tick = (q.cnt == `MCS_UCNT_W'(`MCS_UNIT_CYC - 1));
        rise = tick && !q.pclk;
        if (tick) begin
            d.cnt = '0;
            d.pclk = !q.pclk;
        end else begin
            d.cnt = q.cnt + `MCS_UCNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign proc_clk = q.pclk;

endmodule : mcs_unit_gen

// ### tb/mcs_ext_mem.sv
`timescale 1ns/1ps

// far-side memory: address latched as the address strobe falls
module mcs_ext_mem (
    input wire logic clk_sys,
    input wire logic [31:0] bus,
    input wire logic as_n,
    input wire logic rd_n,
    input wire logic [3:0] wr_n,
    input wire logic [7:0] wait_len,
    output logic [31:0] drv,
    output logic wt
);
    logic [31:0] mem [16];
    logic [31:0] drv_q = 32'h0;
    logic [3:0] a = 4'h0;
    logic as_q = 1'b1;
    logic [7:0] wc = 8'h00;

    // ram answers every address; only bus bits 5:2 pick the word
    assign wt = wc != 8'h00;
    assign drv = drv_q;

    always @(posedge clk_sys) begin
        as_q <= as_n;
        if (as_q && !as_n) begin
            a <= bus[5:2];
            wc <= wait_len;
        end else if (wc != 8'h00) begin
            wc <= wc - 8'h01;
        end
        for (int i = 0; i < 4; i++) begin
            if (!wr_n[i]) begin
                mem[a][8*i+:8] <= bus[8*i+:8];
            end
        end
        // released bus toggles so that a late sample cannot match by luck
        drv_q <= rd_n ? ~drv_q : mem[a];
    end
endmodule : mcs_ext_mem

// ### tb/memory_cycle_strobe_sequencer_tb.sv
`timescale 1ns/1ps
`include "mcs_regs.svh"

module memory_cycle_strobe_sequencer_tb;
    typedef struct packed {
        logic [11:0] tlen;
        logic [19:0] soff;
        logic late;
        logic w;
        logic [3:0] be;
        logic [31:0] d;
    } mcs_row_t;

    localparam logic [31:0] adr_ext = 32'h80001008;
    logic clk_sys, rst, reg_wr, reg_rd, req_valid, req_ready, req_write, rsp_valid, as_q = 1'b1, p;
    logic [7:0] reg_addr, wait_len;
    logic [31:0] reg_wdata, reg_rdata, req_addr, req_wdata, rsp_rdata, adr_seen, drv;
    logic [31:0] muxed_addr_data_bus_i, muxed_addr_data_bus_o;
    logic [3:0] req_be, muxed_addr_data_bus_oe_n, byte_write_strobes_n;
    logic address_valid_strobe_n, config_strobe_a_n, config_strobe_b_n, config_strobe_c_n, config_strobe_d_n;
    logic read_strobe_n, refresh_strobe_n, wait_request_input, interface_setup_input;
    logic bus_request_input, bus_grant_output, processor_clock_output;
    // low cycles: address strobe, a, b, d, read, lane0 drive, writes, c
    int n [8];
    int bad_count, checks_done, bad_oe, sp, s6;
    // write, read, masked write, read with zero offsets
    mcs_row_t rows [4] = '{'{12'h000, 20'h08421, 1'b0, 1'b1, 4'hF, 32'h11223344},
        '{12'hFFF, 20'hFBC7F, 1'b1, 1'b0, 4'hF, 32'h11223344},
        '{12'hC61, 20'h39444, 1'b1, 1'b1, 4'h5, 32'hAABBCCDD},
        '{12'hC61, 20'h00000, 1'b0, 1'b0, 4'hF, 32'h11BB33DD}};

    mcs_sequencer mcs_sequencer_i (
        .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req_valid, .req_ready,
        .req_addr, .req_write, .req_wdata, .req_be, .rsp_valid, .rsp_rdata, .muxed_addr_data_bus_i,
        .muxed_addr_data_bus_o, .muxed_addr_data_bus_oe_n, .address_valid_strobe_n, .config_strobe_a_n,
        .config_strobe_b_n, .config_strobe_c_n, .config_strobe_d_n, .byte_write_strobes_n, .read_strobe_n,
        .refresh_strobe_n, .wait_request_input, .interface_setup_input, .bus_request_input,
        .bus_grant_output, .processor_clock_output
    );

    mcs_ext_mem mcs_ext_mem_i (
        .clk_sys, .bus(muxed_addr_data_bus_i), .as_n(address_valid_strobe_n), .rd_n(read_strobe_n),
        .wr_n(byte_write_strobes_n), .wait_len, .drv, .wt(wait_request_input)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            muxed_addr_data_bus_i[8*i+:8] = muxed_addr_data_bus_oe_n[i] ? drv[8*i+:8] : muxed_addr_data_bus_o[8*i+:8];
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // sampled mid-cycle so every registered output has settled
    always @(negedge clk_sys) begin
        if (req_valid) n = '{default: 0};
        if (as_q && !address_valid_strobe_n) adr_seen = muxed_addr_data_bus_i;
        as_q = address_valid_strobe_n;
        n[0] += !address_valid_strobe_n;
        n[1] += !config_strobe_a_n;
        n[2] += !config_strobe_b_n;
        n[3] += !config_strobe_d_n;
        n[4] += !read_strobe_n;
        n[5] += !muxed_addr_data_bus_oe_n[0];
        n[6] += byte_write_strobes_n != 4'hF;
        n[7] += !config_strobe_c_n;
        if (!read_strobe_n && muxed_addr_data_bus_oe_n !== 4'hF) bad_oe++;
        if (byte_write_strobes_n != 4'hF && muxed_addr_data_bus_oe_n !== ~req_be) bad_oe++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic int ln(input logic [11:0] t, input int i);
        return int'(t[2*i+:2]) + 1;
    endfunction : ln

    // an offset of zero is stored as one
    function automatic int so(input logic [19:0] s, input int k);
        return (s[5*k+:5] == 5'h00) ? 1 : int'(s[5*k+:5]);
    endfunction : so

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("register", exp, reg_rdata);
    endtask : rd_reg

    task automatic rst_dut();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
    endtask : rst_dut

    // config locks, so each setup starts from reset
    task automatic setup(input mcs_row_t r);
        rst_dut();
        wr_reg(`MCS_OFF_TLEN, 32'(r.tlen));
        wr_reg(`MCS_OFF_SOFF, 32'(r.soff));
        rd_reg(`MCS_OFF_TLEN, 32'(r.tlen));
        rd_reg(`MCS_OFF_SOFF, 32'({5'(so(r.soff, 3)), 5'(so(r.soff, 2)), 5'(so(r.soff, 1)), 5'(so(r.soff, 0))}));
        wr_reg(`MCS_OFF_CTRL, {30'h0, r.late, 1'b1});
    endtask : setup

    task automatic access(input logic w, input logic [3:0] be, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_addr <= a;
        req_write <= w;
        req_wdata <= d;
        req_be <= be;
        do begin
            @(negedge clk_sys);
            k++;
        end while (req_ready !== 1'b1 && k < 300);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (rsp_valid !== 1'b1 && k < 600);
        if (k >= 600) begin
            bad_count++;
            print_verdict();
        end
    endtask : access

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mcs_row_t c;
        {rst, reg_wr, reg_rd, req_valid, req_write} = 5'h10;
        {reg_addr, wait_len, reg_wdata, req_addr, req_wdata, req_be} = '0;
        {interface_setup_input, bus_request_input} = 2'h0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[r]) begin
            c = rows[r];
            setup(c);
            access(c.w, c.be, adr_ext, c.d);
            sp = ln(c.tlen, 1) + ln(c.tlen, 2) + ln(c.tlen, 3) + ln(c.tlen, 4);
            s6 = sp + ln(c.tlen, 5);
            chk("address phase", {adr_ext[31:2], 1'b1, !c.w}, adr_seen);
            chk("address strobe", 32'(2 * sp), 32'(n[0]));
            chk("strobe a", 32'(2 * (so(c.soff, 0) < s6 ? so(c.soff, 0) : s6)), 32'(n[1]));
            chk("strobe b", 32'(so(c.soff, 1) < sp ? 2 * (sp - so(c.soff, 1)) : 0), 32'(n[2]));
            chk("strobe c", 32'(so(c.soff, 2) < sp ? 2 * (sp - so(c.soff, 2)) : 0), 32'(n[7]));
            chk("strobe d", 32'(so(c.soff, 3) < sp ? 2 * (sp - so(c.soff, 3)) : 0), 32'(n[3]));
            chk("lane drive", 32'h0, 32'(bad_oe));
            if (c.w) begin
                chk("write strobes", 32'(2 * (sp - ln(c.tlen, 1) - (c.late ? ln(c.tlen, 2) : 0))), 32'(n[6]));
            end else begin
                chk("read data", c.d, rsp_rdata);
                chk("read strobe", 32'(2 * (ln(c.tlen, 3) + ln(c.tlen, 4))), 32'(n[4]));
                chk("address drive", 32'(2 * (ln(c.tlen, 0) + ln(c.tlen, 1))), 32'(n[5]));
            end
        end
        // awkward: wait units while strobe a keeps its own count
        setup('{12'h000, 20'h08422, 1'b0, 1'b0, 4'hF, 32'h0});
        wait_len <= 8'h14;
        access(1'b0, 4'hF, adr_ext, 32'h0);
        wait_len <= 8'h00;
        chk("strobe a with waits", 32'h4, 32'(n[1]));
        chk("wait stretch", 32'h1, 32'(n[0] > 20));
        chk("wait phase", 32'h0, 32'(n[0] % 4));
        chk("read after wait", 32'h11BB33DD, rsp_rdata);
        wr_reg(`MCS_OFF_TLEN, 32'h00000555);
        rd_reg(`MCS_OFF_TLEN, 32'h0);
        access(1'b1, 4'hF, 32'h80000070, 32'h5A3C0123);
        access(1'b0, 4'hF, 32'h80000070, 32'h0);
        chk("internal data", 32'h5A3C0123, rsp_rdata);
        access(1'b0, 4'hF, 32'h80000FFC, 32'h0);
        chk("internal cycle", 32'h0, 32'(n[0]));
        p = processor_clock_output;
        repeat (2) @(negedge clk_sys);
        chk("proc clock", 32'(!p), 32'(processor_clock_output));
        @(posedge clk_sys);
        {bus_request_input, interface_setup_input} <= 2'h3;
        repeat (8) @(negedge clk_sys);
        chk("grant", 32'h1, 32'(bus_grant_output));
        chk("ready while granted", 32'h0, 32'(req_ready));
        chk("bus released", 32'hF, 32'(muxed_addr_data_bus_oe_n));
        chk("no refresh", 32'h1, 32'(refresh_strobe_n));
        rd_reg(`MCS_OFF_STAT, 32'h00000061);
        @(posedge clk_sys);
        bus_request_input <= 1'b0;
        repeat (8) @(negedge clk_sys);
        chk("grant dropped", 32'h0, 32'(bus_grant_output));
        print_verdict();
    end
endmodule : memory_cycle_strobe_sequencer_tb
